// ---- rtl/bcs_pkg.sv ----
// Constants for the board control and status register set.
// Assumes a single 10 MHz core clock and SMBus byte-data access.
`default_nettype none

package bcs_pkg;
  // Command codes
  localparam logic [7:0] CMD_CTRL_WR   = 8'ha0;
  localparam logic [7:0] CMD_CTRL_RD   = 8'ha1;
  localparam logic [7:0] POWER_FAIL_STATUS_LOW_CLR = 8'hb0;
  localparam logic [7:0] POWER_FAIL_STATUS_LOW_RD  = 8'hb1;
  localparam logic [7:0] WATCHDOG_POWER_STATUS_CLR = 8'hb2;
  localparam logic [7:0] WATCHDOG_POWER_STATUS_RD  = 8'hb3;
  localparam logic [7:0] CMD_REV_RD    = 8'hc1;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;
  // Control bit positions
  localparam int CTRL_GREEN = 7;
  localparam int CTRL_HDIS  = 6;
  localparam int CTRL_HACT  = 5;
  localparam int CTRL_TSHI  = 4;
  localparam int CTRL_TSLO  = 3;
  localparam int CTRL_KICK  = 2;
  localparam int CTRL_RED   = 1;
  localparam int CTRL_SOFT_SYSTEM_RESET  = 0;
  // Status bit positions
  localparam int ST0_1V8    = 7;
  localparam int ST0_1V35   = 4;
  localparam int ST1_ARMED  = 7;
  localparam int ST1_WDRST  = 6;
  localparam int ST1_HALF   = 5;
  localparam int ST1_12V    = 4;
  localparam int ST1_5V     = 3;
  localparam int ST1_3V3    = 0;
  // Sticky flag vector layout
  localparam int FLG_1V8 = 5;
  localparam int FLG_1V35 = 4;
  localparam int FLG_WDRST = 3;
  localparam int FLG_12V = 2;
  localparam int FLG_5V = 1;
  localparam int FLG_3V3 = 0;
  localparam int FLG_N = 6;
  localparam int FLG_N0 = 2;  // Flags owned by status register 0
  // Identity, values arbitrary
  localparam logic [6:0] TARGET_ADDR_DEF = 7'h2e;
  localparam logic [7:0] LOGIC_REV_DEF   = 8'h01;
  // Timing
  localparam longint unsigned CLK_HZ     = 10_000_000;
  localparam longint unsigned WD_T0_S    = 2;
  localparam longint unsigned WD_T1_S    = 10;
  localparam longint unsigned WD_T2_S    = 50;
  localparam longint unsigned WD_T3_S    = 250;
  localparam longint unsigned BLINK_MS   = 500;
  localparam logic [31:0] WD_CYC0_DEF    = 32'(WD_T0_S * CLK_HZ);
  localparam logic [31:0] WD_CYC1_DEF    = 32'(WD_T1_S * CLK_HZ);
  localparam logic [31:0] WD_CYC2_DEF    = 32'(WD_T2_S * CLK_HZ);
  localparam logic [31:0] WD_CYC3_DEF    = 32'(WD_T3_S * CLK_HZ);
  localparam logic [31:0] BLINK_CYC_DEF  = 32'(BLINK_MS * CLK_HZ / 1000);
  // Timeout select {hi,lo}
  localparam logic [1:0] TSEL_2S   = 2'b00;
  localparam logic [1:0] TSEL_10S  = 2'b10;
  localparam logic [1:0] TSEL_50S  = 2'b01;
  localparam logic [1:0] TSEL_250S = 2'b11;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Target states, Gray along the write path
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_ADDR  = 4'h1,
    ST_ACK_A = 4'h3,
    ST_CMD   = 4'h2,
    ST_ACK_C = 4'h6,
    ST_WDATA = 4'h7,
    ST_ACK_W = 4'h5,
    ST_RDATA = 4'h4,
    ST_RACK  = 4'hc
  } bcs_state_e;
endpackage

`default_nettype wire

// ---- rtl/bcs_regs.sv ----
// Board control and status registers behind an SMBus byte-data target.
// Assumes SMBus pins synchronous to core_clk_i, sda driven open-drain
// by the pad from smb_sda_oe_o, and a separate power-on reset.
//
// Overview of operation
// - Control register resets to 0x00.
// - Control written at 0xa0, read at 0xa1.
// - Control bit 7 lights green LED.
// - Control bit 6 set ignores handle switch.
// - Bit 5 picks power event or reset.
// - Bits 4:3 select 2/10/50/250 s timeout.
// - Any kick bit edge restarts watchdog.
// - Watchdog idle until first kick edge.
// - Control bit 1 blinks red LED.
// - Control bit 0 set requests system reset.
// - Status 0 cleared at 0xb0, read 0xb1.
// - Status 0 bits 7,4 flag 1.8/1.35 V.
// - Reserved status bits always read zero.
// - Status 0 bits sticky across system reset.
// - Any status write clears its sticky bits.
// - Status 1 sticky except armed and half.
// - Status 1 cleared at 0xb2, read 0xb3.
// - Status 1 bit 7 shows watchdog armed.
// - Status 1 bit 6 flags watchdog reset.
// - Status 1 bit 5 shows half elapsed.
// - Status 1 bit 4 flags 12 V absent.
// - Status 1 bits 3,0 flag 5/3.3 V.
// - Revision read at 0xc1, never written.
`default_nettype none

module bcs_regs #(
  parameter logic [6:0]  TARGET_ADDR = bcs_pkg::TARGET_ADDR_DEF,
  parameter logic [7:0]  LOGIC_REV   = bcs_pkg::LOGIC_REV_DEF,
  parameter logic [31:0] WD_CYC0     = bcs_pkg::WD_CYC0_DEF,
  parameter logic [31:0] WD_CYC1     = bcs_pkg::WD_CYC1_DEF,
  parameter logic [31:0] WD_CYC2     = bcs_pkg::WD_CYC2_DEF,
  parameter logic [31:0] WD_CYC3     = bcs_pkg::WD_CYC3_DEF,
  parameter logic [31:0] BLINK_CYC   = bcs_pkg::BLINK_CYC_DEF
) (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic por_i,
  input  wire logic smb_scl_i,
  input  wire logic smb_sda_i,
  output logic      smb_sda_o,
  output logic      smb_sda_oe_o,
  input  wire logic handle_sw_i,
  input  wire logic fail_1v8_i,
  input  wire logic fail_1v35_i,
  input  wire logic fail_5v_i,
  input  wire logic fail_3v3_i,
  input  wire logic rail_12v_absent_i,
  output logic      green_led_on_o,
  output logic      red_led_o,
  output logic      power_event_o,
  output logic      sys_reset_req_o
);
  import bcs_pkg::*;

  logic             rst_any;
  logic             scl_q;
  logic             sda_q;
  logic             scl_rise;
  logic             scl_fall;
  logic             bus_start;
  logic             bus_stop;
  logic             byte_done;
  bcs_state_e       st;
  logic [3:0]       bit_cnt;
  logic [7:0]       shreg;
  logic [7:0]       cmd;
  logic [7:0]       wdata;
  logic [7:0]       tx;
  logic             rw;
  logic             wr_stb;
  logic [7:0]       board_control;
  logic [7:0]       stat0;
  logic [7:0]       stat1;
  logic [7:0]       rd_mux;
  logic [FLG_N-1:0] flag;
  logic [FLG_N-1:0] flag_set;
  logic [FLG_N-1:0] flag_clr;
  logic             clr0;
  logic             clr1;
  logic             wd_armed;
  logic             wd_half_elapsed;
  logic             wd_expire;
  logic             sw_q;
  logic             press;
  logic             handle_rst;
  logic [31:0]      blink_cnt;
  logic             blink_phase;

  // Board reset clears control state; sticky flags ignore it
  assign rst_any = sys_rst_i | por_i;

  // Open-drain data pin only ever pulls low
  assign smb_sda_o = 1'b0;

  // Previous pin samples for edge and condition detection
  always_ff @(posedge core_clk_i) begin
    if (por_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= smb_scl_i;
      sda_q <= smb_sda_i;
    end
  end

  // Bus events
  assign scl_rise  = smb_scl_i & ~scl_q;
  assign scl_fall  = ~smb_scl_i & scl_q;
  assign bus_start = smb_scl_i & scl_q & sda_q & ~smb_sda_i;
  assign bus_stop  = smb_scl_i & scl_q & ~sda_q & smb_sda_i;
  assign byte_done = scl_fall && (bit_cnt == BYTE_BITS);

  // Bit counter and receive shifter; ack bits shift in too
  always_ff @(posedge core_clk_i) begin
    if (por_i || bus_start) begin
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
    end else begin
      if (scl_rise) begin
        shreg <= {shreg[6:0], smb_sda_i};
        if (st == ST_ADDR || st == ST_CMD || st == ST_WDATA || st == ST_RDATA) begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end else if (byte_done) begin
        bit_cnt <= 4'h0;
      end
    end
  end

  // Target sequencer; only power-on resets it so a write that
  // requests a board reset still finishes its acknowledge
  always_ff @(posedge core_clk_i) begin
    if (por_i) begin
      st           <= ST_IDLE;
      cmd          <= 8'h00;
      wdata        <= 8'h00;
      tx           <= 8'h00;
      rw           <= 1'b0;
      wr_stb       <= 1'b0;
      smb_sda_oe_o <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (bus_start) begin
        st           <= ST_ADDR;
        smb_sda_oe_o <= 1'b0;
      end else if (bus_stop) begin
        st           <= ST_IDLE;
        smb_sda_oe_o <= 1'b0;
      end else begin
        case (st)
          ST_IDLE: begin
            smb_sda_oe_o <= 1'b0;
          end
          ST_ADDR: begin
            if (byte_done) begin
              if (shreg[7:1] == TARGET_ADDR) begin
                st           <= ST_ACK_A;
                rw           <= shreg[0];
                smb_sda_oe_o <= 1'b1;
              end else begin
                st <= ST_IDLE;
              end
            end
          end
          ST_ACK_A: begin
            if (scl_fall) begin
              if (rw) begin
                st           <= ST_RDATA;
                tx           <= rd_mux;
                smb_sda_oe_o <= ~rd_mux[7];
              end else begin
                st           <= ST_CMD;
                smb_sda_oe_o <= 1'b0;
              end
            end
          end
          ST_CMD: begin
            if (byte_done) begin
              st           <= ST_ACK_C;
              cmd          <= shreg;
              smb_sda_oe_o <= 1'b1;
            end
          end
          ST_ACK_C: begin
            if (scl_fall) begin
              st           <= ST_WDATA;
              smb_sda_oe_o <= 1'b0;
            end
          end
          ST_WDATA: begin
            if (byte_done) begin
              st           <= ST_ACK_W;
              wdata        <= shreg;
              wr_stb       <= 1'b1;
              smb_sda_oe_o <= 1'b1;
            end
          end
          ST_ACK_W: begin
            if (scl_fall) begin
              st           <= ST_WDATA;
              smb_sda_oe_o <= 1'b0;
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == BYTE_BITS) begin
                st           <= ST_RACK;
                smb_sda_oe_o <= 1'b0;
              end else begin
                tx           <= {tx[6:0], 1'b0};
                smb_sda_oe_o <= ~tx[6];
              end
            end
          end
          ST_RACK: begin
            // Host ack keeps the byte streaming, nack ends the read
            if (scl_fall) begin
              if (!shreg[0]) begin
                st           <= ST_RDATA;
                tx           <= rd_mux;
                smb_sda_oe_o <= ~rd_mux[7];
              end else begin
                st           <= ST_IDLE;
                smb_sda_oe_o <= 1'b0;
              end
            end
          end
          default: begin
            st           <= ST_IDLE;
            smb_sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // Control register
  always_ff @(posedge core_clk_i) begin
    if (rst_any) begin
      board_control <= CTRL_RST;
    end else if (wr_stb && cmd == CMD_CTRL_WR) begin
      board_control <= wdata;
    end
  end

  // Write to a status code clears, data ignored; others dropped
  assign clr0 = wr_stb && (cmd == POWER_FAIL_STATUS_LOW_CLR);
  assign clr1 = wr_stb && (cmd == WATCHDOG_POWER_STATUS_CLR);

  // Sticky cause sources
  always_comb begin
    flag_set            = '0;
    flag_set[FLG_1V8]   = fail_1v8_i;
    flag_set[FLG_1V35]  = fail_1v35_i;
    flag_set[FLG_WDRST] = wd_expire;
    flag_set[FLG_12V]   = rail_12v_absent_i;
    flag_set[FLG_5V]    = fail_5v_i;
    flag_set[FLG_3V3]   = fail_3v3_i;
  end
  assign flag_clr = {{FLG_N0{clr0}}, {(FLG_N - FLG_N0){clr1}}};

  // Sticky flags; set beats a same-cycle clear so no event is lost
  for (genvar i = 0; i < FLG_N; i++) begin : g_flag
    always_ff @(posedge core_clk_i) begin
      if (por_i) begin
        flag[i] <= 1'b0;
      end else if (flag_set[i]) begin
        flag[i] <= 1'b1;
      end else if (flag_clr[i]) begin
        flag[i] <= 1'b0;
      end
    end
  end

  // Status images; unlisted bits stay zero
  always_comb begin
    stat0            = 8'h00;
    stat0[ST0_1V8]   = flag[FLG_1V8];
    stat0[ST0_1V35]  = flag[FLG_1V35];
    stat1            = 8'h00;
    stat1[ST1_ARMED] = wd_armed;
    stat1[ST1_WDRST] = flag[FLG_WDRST];
    stat1[ST1_HALF]  = wd_half_elapsed;
    stat1[ST1_12V]   = flag[FLG_12V];
    stat1[ST1_5V]    = flag[FLG_5V];
    stat1[ST1_3V3]   = flag[FLG_3V3];
  end

  // Read data by command; write-only codes read as zero
  always_comb begin
    case (cmd)
      CMD_CTRL_RD:  rd_mux = board_control;
      POWER_FAIL_STATUS_LOW_RD: rd_mux = stat0;
      WATCHDOG_POWER_STATUS_RD: rd_mux = stat1;
      CMD_REV_RD:   rd_mux = LOGIC_REV;
      default:      rd_mux = RD_UNMAPPED;
    endcase
  end

  // Watchdog
  bcs_watchdog #(
    .CYC0 (WD_CYC0),
    .CYC1 (WD_CYC1),
    .CYC2 (WD_CYC2),
    .CYC3 (WD_CYC3)
  ) u_wd (
    .clk_i    (core_clk_i),
    .rst_i    (rst_any),
    .kick_i   (board_control[CTRL_KICK]),
    .sel_i    ({board_control[CTRL_TSHI], board_control[CTRL_TSLO]}),
    .armed_o  (wd_armed),
    .half_o   (wd_half_elapsed),
    .expire_o (wd_expire)
  );

  // Handle switch press edge, gated by the disable bit
  always_ff @(posedge core_clk_i) begin
    if (rst_any) sw_q <= 1'b0;
    else sw_q <= handle_sw_i;
  end
  assign press      = handle_sw_i & ~sw_q & ~board_control[CTRL_HDIS];
  assign handle_rst = press & board_control[CTRL_HACT];

  // One-cycle power event pulse
  always_ff @(posedge core_clk_i) begin
    if (rst_any) power_event_o <= 1'b0;
    else power_event_o <= press & ~board_control[CTRL_HACT];
  end

  // Reset request holds until the board reset arrives
  always_ff @(posedge core_clk_i) begin
    if (rst_any) begin
      sys_reset_req_o <= 1'b0;
    end else if (board_control[CTRL_SOFT_SYSTEM_RESET] | wd_expire | handle_rst) begin
      sys_reset_req_o <= 1'b1;
    end
  end

  // Blink timebase, free running
  always_ff @(posedge core_clk_i) begin
    if (rst_any) begin
      blink_cnt   <= 32'h0;
      blink_phase <= 1'b0;
    end else if (blink_cnt >= BLINK_CYC - 32'h1) begin
      blink_cnt   <= 32'h0;
      blink_phase <= ~blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // LED drives
  always_ff @(posedge core_clk_i) begin
    if (rst_any) begin
      green_led_on_o <= 1'b0;
      red_led_o      <= 1'b0;
    end else begin
      green_led_on_o <= board_control[CTRL_GREEN];
      red_led_o      <= board_control[CTRL_RED] & blink_phase;
    end
  end
endmodule

`default_nettype wire

// ---- rtl/bcs_watchdog.sv ----
// Watchdog timer with four selectable timeouts.
// Assumes kick_i comes from a register that resets to 0 with rst_i.
`default_nettype none

module bcs_watchdog #(
  parameter logic [31:0] CYC0 = bcs_pkg::WD_CYC0_DEF,
  parameter logic [31:0] CYC1 = bcs_pkg::WD_CYC1_DEF,
  parameter logic [31:0] CYC2 = bcs_pkg::WD_CYC2_DEF,
  parameter logic [31:0] CYC3 = bcs_pkg::WD_CYC3_DEF
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       kick_i,
  input  wire logic [1:0] sel_i,
  output logic            armed_o,
  output logic            half_o,
  output logic            expire_o
);
  import bcs_pkg::*;

  logic        kick_q;
  logic        toggle;
  logic [31:0] cnt;
  logic [31:0] limit;

  // Selected timeout in cycles
  always_comb begin
    case (sel_i)
      TSEL_2S:   limit = CYC0;
      TSEL_10S:  limit = CYC1;
      TSEL_50S:  limit = CYC2;
      TSEL_250S: limit = CYC3;
      default:   limit = CYC0;
    endcase
  end

  // Either edge of the kick bit counts
  always_ff @(posedge clk_i) begin
    if (rst_i) kick_q <= 1'b0;
    else kick_q <= kick_i;
  end
  assign toggle = kick_i ^ kick_q;

  // Counter; idle after reset until the first kick edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_o  <= 1'b0;
      cnt      <= 32'h0;
      half_o   <= 1'b0;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (toggle) begin
        armed_o <= 1'b1;
        cnt     <= 32'h0;
        half_o  <= 1'b0;
      end else if (armed_o) begin
        // Compare with >= so a shorter timeout picked mid-run still fires
        if (cnt >= limit - 32'h1) begin
          expire_o <= 1'b1;
          armed_o  <= 1'b0;
          cnt      <= 32'h0;
          half_o   <= 1'b0;
        end else begin
          cnt    <= cnt + 32'h1;
          half_o <= (cnt + 32'h1) >= (limit >> 1);
        end
      end
    end
  end
endmodule

`default_nettype wire

// ---- testbench/bcs_host_model.sv ----
// SMBus host model issuing byte-data transfers only.
// Assumes a pulled-up sda wire built by the bench from all enables.
`default_nettype none

module bcs_host_model #(
  parameter logic [6:0] ADDR = 7'h2e
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic nack;

  // Bus idle, both lines released
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    nack = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One bit: low 4 cycles, high 3, sampled at the 2nd high edge
  task automatic bitx(input logic b, output logic r);
    sda_oe_o <= ~b;
    tk(3);
    scl_o <= 1'b1;
    tk(2);
    r = sda_i;
    tk(1);
    scl_o <= 1'b0;
    tk(1);
  endtask

  // Start or repeated start; aligns to an edge first
  task automatic start_c();
    @(posedge clk_i);
    sda_oe_o <= 1'b0;
    tk(2);
    scl_o <= 1'b1;
    tk(3);
    sda_oe_o <= 1'b1;
    tk(3);
    scl_o <= 1'b0;
    tk(1);
  endtask

  task automatic stop_c();
    sda_oe_o <= 1'b1;
    tk(3);
    scl_o <= 1'b1;
    tk(3);
    sda_oe_o <= 1'b0;
    tk(3);
  endtask

  // Eight bits MSB first, then a released ack slot
  task automatic byte_x(input logic [7:0] b, input logic want_ack, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], r);
      q[i] = r;
    end
    bitx(1'b1, r);
    if (want_ack && r !== 1'b0) nack = 1'b1;
  endtask

  // Byte-data write, one data byte
  task automatic wr(input logic [7:0] cmd, input logic [7:0] b);
    logic [7:0] q;
    start_c();
    byte_x({ADDR, 1'b0}, 1'b1, q);
    byte_x(cmd, 1'b1, q);
    byte_x(b, 1'b1, q);
    stop_c();
  endtask

  // Byte-data read, host ends with a nack
  task automatic rd(input logic [7:0] cmd, output logic [7:0] b);
    logic [7:0] q;
    start_c();
    byte_x({ADDR, 1'b0}, 1'b1, q);
    byte_x(cmd, 1'b1, q);
    start_c();
    byte_x({ADDR, 1'b1}, 1'b1, q);
    byte_x(8'hff, 1'b0, b);
    stop_c();
  endtask
endmodule

`default_nettype wire

// ---- testbench/bcs_regs_props.sv ----
// Port checker for the board control and status registers.
// Assumes one core clock; por_i clears all, sys_rst_i the board side.
`default_nettype none

module bcs_regs_props #(
  parameter logic [31:0] BLINK_CYC = 32'd4
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic por_i,
  input wire logic smb_scl_i,
  input wire logic smb_sda_oe_o,
  input wire logic handle_sw_i,
  input wire logic green_led_on_o,
  input wire logic red_led_o,
  input wire logic power_event_o,
  input wire logic sys_reset_req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  hs;
  logic [31:0] red_cnt;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (por_i);

  // Handle history, so an event can be traced to its edge
  always_ff @(posedge core_clk_i) begin
    hs <= {hs[2:0], handle_sw_i};
  end

  // Run length of red on-time; a stuck blinker grows it without bound
  always_ff @(posedge core_clk_i) begin
    red_cnt <= red_led_o ? red_cnt + 32'd1 : 32'd0;
  end

  rst_quiet_a: assert property ($fell(sys_rst_i) |-> !green_led_on_o && !red_led_o && !sys_reset_req_o)
    else $error("outputs not quiet after system reset");
  por_idle_a: assert property ($fell(por_i) |-> !smb_sda_oe_o && !sys_reset_req_o && !power_event_o)
    else $error("sda or request active after power-on reset");
  req_hold_a: assert property (sys_reset_req_o && !sys_rst_i |=> sys_reset_req_o)
    else $error("reset request dropped before system reset");
  ev_cause_a: assert property (power_event_o |-> (hs[0] && !hs[1]) || (hs[1] && !hs[2]) || (hs[2] && !hs[3]))
    else $error("power event without handle edge");
  ev_pulse_a: assert property (power_event_o |=> !power_event_o)
    else $error("power event longer than one cycle");
  red_period_a: assert property (red_cnt <= BLINK_CYC)
    else $error("red led on longer than blink half period");
  green_sync_a: assert property ($changed(green_led_on_o) |-> !smb_scl_i || $past(sys_rst_i) || $past(sys_rst_i, 2))
    else $error("green led moved outside a write");
  sda_hold_a: assert property (smb_scl_i && $past(smb_scl_i) |-> $stable(smb_sda_oe_o))
    else $error("sda moved while scl high");
  sda_move_a: assert property ($changed(smb_sda_oe_o) |-> !smb_scl_i && !$past(smb_scl_i))
    else $error("sda moved too close to scl rise");
endmodule

bind bcs_regs bcs_regs_props #(.BLINK_CYC(BLINK_CYC)) chk (
  .core_clk_i(core_clk_i),
  .sys_rst_i(sys_rst_i),
  .por_i(por_i),
  .smb_scl_i(smb_scl_i),
  .smb_sda_oe_o(smb_sda_oe_o),
  .handle_sw_i(handle_sw_i),
  .green_led_on_o(green_led_on_o),
  .red_led_o(red_led_o),
  .power_event_o(power_event_o),
  .sys_reset_req_o(sys_reset_req_o)
);

`default_nettype wire

// ---- testbench/board_control_status_regs_bench.sv ----
// Self-checking bench for the register set behind the SMBus host model.
// Assumes shortened watchdog and blink counts given to the design here.
`default_nettype none

module board_control_status_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import bcs_pkg::*;
  localparam logic [7:0]  REV = 8'h5a;  // Arbitrary revision value
  localparam logic [31:0] CYC [4] = '{32'd2000, 32'd3000, 32'd4000, 32'd5000};
  localparam logic [1:0]  SEL [4] = '{TSEL_2S, TSEL_10S, TSEL_50S, TSEL_250S};
  logic       clk, rst, por, hsw, f18, f135, f5, f33, a12;
  logic       h_oe, d_oe, d_sda, scl, grn, red, pev, req;
  logic [7:0] d;
  wire        sda_w;
  int         mismatches, n_checks, cyc;

  // Pulled-up wire: low while any party pulls it
  assign sda_w = !(h_oe || (d_oe && !d_sda));

  bcs_regs #(.LOGIC_REV(REV), .WD_CYC0(CYC[0]), .WD_CYC1(CYC[1]), .WD_CYC2(CYC[2]), .WD_CYC3(CYC[3]),
    .BLINK_CYC(32'd4)) uut (
    .core_clk_i(clk), .sys_rst_i(rst), .por_i(por), .smb_scl_i(scl), .smb_sda_i(sda_w),
    .smb_sda_o(d_sda), .smb_sda_oe_o(d_oe), .handle_sw_i(hsw), .fail_1v8_i(f18), .fail_1v35_i(f135),
    .fail_5v_i(f5), .fail_3v3_i(f33), .rail_12v_absent_i(a12), .green_led_on_o(grn), .red_led_o(red),
    .power_event_o(pev), .sys_reset_req_o(req));

  bcs_host_model #(.ADDR(TARGET_ADDR_DEF)) host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(h_oe));

  // 10 MHz core clock and a cycle count for timing checks
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic sreset();
    rst <= 1'b1;
    tk(2);
    rst <= 1'b0;
    tk(1);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Expected status images from a mask {1v8, 1v35, 12v, 5v, 3v3}
  function automatic logic [7:0] exp0(input logic [4:0] m);
    return {m[4], 2'b00, m[3], 4'h0};
  endfunction
  function automatic logic [7:0] exp1(input logic [4:0] m);
    return {3'b000, m[2], m[1], 2'b00, m[0]};
  endfunction

  // Whole run is near 40k cycles; 60k leaves margin yet stays short
  initial begin
    #(100 * 60000);
    mismatches++;
    finish_test();
  end

  initial begin
    logic [7:0] v;
    logic [4:0] m;
    int n;
    {rst, por, hsw, f18, f135, f5, f33, a12} = 8'hc0;
    mismatches = 0;
    n_checks = 0;
    cyc = 0;
    void'($urandom(11));
    tk(2);
    rst <= 1'b0;
    por <= 1'b0;
    tk(1);
    host.rd(CMD_CTRL_RD, d);
    chk(d, CTRL_RST);
    host.rd(CMD_REV_RD, d);
    chk(d, REV);
    $display("test reset done");
    // Control write and read-back, kick and soft reset bits kept low
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 8'hfa : (k == 1) ? 8'h00 : 8'($urandom) & 8'hfa;
      host.wr(CMD_CTRL_WR, v);
      host.rd(CMD_CTRL_RD, d);
      chk(d, v);
      chk(grn, v[7]);
    end
    // Writes to unused codes are ignored, unmapped reads give zero;
    // read-only codes are never written, the host must not do so
    host.wr(8'h5a, 8'hff);
    host.wr(8'hc0, 8'hff);
    host.rd(CMD_CTRL_RD, d);
    chk(d, v);
    host.rd(CMD_REV_RD, d);
    chk(d, REV);
    host.rd(8'h5a, d);
    chk(d, RD_UNMAPPED);
    chk(host.nack, 1'b0);
    $display("test control done");
    host.wr(CMD_CTRL_WR, 8'h02);
    n = 0;
    repeat (64) begin
      @(posedge clk);
      n += (red === 1'b1);
    end
    chk(n, 32);
    host.wr(CMD_CTRL_WR, 8'h00);
    chk(red, 1'b0);
    $display("test blink done");
    // Sticky flags: all set, then a random set
    for (int k = 0; k < 2; k++) begin
      m = k ? 5'($urandom) : 5'h1f;
      @(posedge clk);
      {f18, f135, a12, f5, f33} <= m;
      tk(4);
      {f18, f135, a12, f5, f33} <= 5'h00;
      sreset();
      host.rd(POWER_FAIL_STATUS_LOW_RD, d);
      chk(d, exp0(m));
      host.rd(WATCHDOG_POWER_STATUS_RD, d);
      chk(d, exp1(m));
      host.wr(POWER_FAIL_STATUS_LOW_CLR, 8'($urandom));
      host.rd(POWER_FAIL_STATUS_LOW_RD, d);
      chk(d, 8'h00);
      host.rd(WATCHDOG_POWER_STATUS_RD, d);
      chk(d, exp1(m));
      host.wr(WATCHDOG_POWER_STATUS_CLR, 8'($urandom));
      host.rd(WATCHDOG_POWER_STATUS_RD, d);
      chk(d, 8'h00);
    end
    $display("test status done");
    // Handle switch in all four enable and action modes
    for (int k = 0; k < 4; k++) begin
      host.wr(CMD_CTRL_WR, {1'b0, k[1], k[0], 5'h00});
      hsw <= 1'b1;
      n = 0;
      repeat (6) begin
        @(posedge clk);
        n += (pev === 1'b1);
      end
      chk(n, k == 0);
      @(negedge clk);
      chk(req, k == 1);
      @(posedge clk);
      hsw <= 1'b0;
      sreset();
    end
    $display("test handle done");
    host.wr(CMD_CTRL_WR, 8'h81);
    @(negedge clk);
    chk(req, 1'b1);
    @(posedge clk);
    sreset();
    host.rd(CMD_CTRL_RD, d);
    chk(d, CTRL_RST);
    chk(grn, 1'b0);
    $display("test soft reset done");
    host.rd(WATCHDOG_POWER_STATUS_RD, d);
    chk(d, 8'h00);
    // Each timeout: arm, see half, restart by the falling kick, expire
    for (int k = 0; k < 4; k++) begin
      v = {3'b000, SEL[k], 3'b000};
      host.wr(CMD_CTRL_WR, v | 8'h04);
      host.rd(WATCHDOG_POWER_STATUS_RD, d);
      chk(d, 8'h80);
      tk(int'(CYC[k] / 2));
      host.rd(WATCHDOG_POWER_STATUS_RD, d);
      chk(d, 8'ha0);
      host.wr(CMD_CTRL_WR, v);
      n = cyc;
      while (req !== 1'b1 && cyc - n < int'(CYC[k]) + 100) @(posedge clk);
      chk(cyc - n >= int'(CYC[k]) - 40 && cyc - n <= int'(CYC[k]), 1'b1);
      sreset();
      host.rd(WATCHDOG_POWER_STATUS_RD, d);
      chk(d, 8'h40);
      host.wr(WATCHDOG_POWER_STATUS_CLR, 8'h00);
    end
    chk(host.nack, 1'b0);
    $display("test watchdog done");
    finish_test();
  end
endmodule

`default_nettype wire
